//--- skip_exec_pkg.sv
package skip_exec_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int PWORD_W = 16;
  localparam int BIT_SEL_W = 3;
  localparam int PTR_W = 8;

  // ----------------------------------------
  // Field positions of a program word
  // ----------------------------------------
  localparam int PWORD_LO_LSB = 0;
  localparam int PWORD_HI_LSB = 8;

  // ----------------------------------------
  // Reset values and the zero byte
  // ----------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_FLAG_RST = 1'b0;
  localparam logic [DATA_W-1:0] TABLE_HIGH_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_SKIP_IF_BYTE_ZERO = 3'b000,
    OP_SKIP_IF_ZERO_LOAD_ACC = 3'b001,
    OP_SKIP_IF_BIT_ZERO = 3'b010,
    OP_TABLE_READ_CURRENT = 3'b011,
    OP_TABLE_READ_LAST_PAGE = 3'b100,
    OP_XOR_INTO_ACC = 3'b101,
    OP_XOR_INTO_MEMORY = 3'b110,
    OP_XOR_IMMEDIATE = 3'b111
  } op_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_TABLE = 2'b10,
    ST_DUMMY = 2'b11
  } state_t;

endpackage : skip_exec_pkg

//--- alu_if.sv
`timescale 1ns/1ps
interface alu_if;
  import skip_exec_pkg::*;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] operand;
  logic [BIT_SEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] xor_result;
  logic xor_zero;
  logic byte_zero;
  logic bit_clear;
  modport core (
    output acc, operand, bit_sel,
    input xor_result, xor_zero, byte_zero, bit_clear
  );
  modport alu (
    input acc, operand, bit_sel,
    output xor_result, xor_zero, byte_zero, bit_clear
  );
endinterface : alu_if

//--- xor_skip_alu.sv
`timescale 1ns/1ps
module xor_skip_alu (
  // Operands and results
  alu_if.alu port
);
  import skip_exec_pkg::*;

  always_comb begin
    port.xor_result = port.acc ^ port.operand;
    port.xor_zero = (port.xor_result == BYTE_ZERO);
    port.byte_zero = (port.operand == BYTE_ZERO);
    port.bit_clear = ~port.operand[port.bit_sel];
  end

endmodule : xor_skip_alu

//--- skip_table_xor_exec.sv
`timescale 1ns/1ps
module skip_table_xor_exec #(
  parameter int DADDR_W = 8,
  parameter int PMEM_AW = 12,
  parameter bit HAS_PTR_HIGH = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction request
  input wire logic instr_valid,
  output logic instr_ready,
  input wire skip_exec_pkg::op_t instr_op,
  input wire logic [DADDR_W-1:0] instr_addr,
  input wire logic [skip_exec_pkg::BIT_SEL_W-1:0] instr_bit,
  input wire logic [skip_exec_pkg::DATA_W-1:0] instr_imm,
  // Completion
  output logic done,
  output logic skip,
  // Table pointers
  input wire logic [skip_exec_pkg::PTR_W-1:0] table_pointer_low,
  input wire logic [skip_exec_pkg::PTR_W-1:0] table_pointer_high,
  // Data memory
  output logic [DADDR_W-1:0] dmem_addr,
  output logic dmem_rd,
  input wire logic [skip_exec_pkg::DATA_W-1:0] dmem_rdata,
  output logic dmem_we,
  output logic [skip_exec_pkg::DATA_W-1:0] dmem_wdata,
  // Program memory
  output logic [PMEM_AW-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [skip_exec_pkg::PWORD_W-1:0] pmem_rdata,
  // Core state
  output logic [skip_exec_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  output logic [skip_exec_pkg::DATA_W-1:0] table_high_byte_reg
);
  import skip_exec_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (PMEM_AW <= PTR_W || PMEM_AW > 2 * PTR_W) begin : g_bad_aw
    $error("PMEM_AW must lie between 9 and 16");
  end
  if (DADDR_W < 1) begin : g_bad_daddr
    $error("DADDR_W must be at least 1");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t state, next_state;
  op_t op_q, next_op_q;
  logic [BIT_SEL_W-1:0] bit_q, next_bit_q;
  logic [DATA_W-1:0] next_acc, next_table_high, next_dmem_wdata;
  logic next_zero_flag, next_done, next_skip;
  logic [DADDR_W-1:0] next_dmem_addr;
  logic next_dmem_rd, next_dmem_we, next_pmem_rd;
  logic [PMEM_AW-1:0] next_pmem_addr, cur_page_addr, last_page_addr;
  logic accept;
  logic [2*PTR_W-1:0] ptr_full;

  alu_if alu ();
  xor_skip_alu u_alu (
    .port(alu.alu)
  );

  assign instr_ready = (state == ST_IDLE);
  assign accept = instr_valid && instr_ready;

  // ----------------------------------------
  // Table address forming
  // ----------------------------------------
  // Without a high pointer a current-page read reaches only the first page
  assign ptr_full = {table_pointer_high, table_pointer_low};
  assign cur_page_addr = HAS_PTR_HIGH ? ptr_full[PMEM_AW-1:0]
                       : {{(PMEM_AW-PTR_W){1'b0}}, table_pointer_low};
  assign last_page_addr = {{(PMEM_AW-PTR_W){1'b1}}, table_pointer_low};

  // ----------------------------------------
  // Operand steering
  // ----------------------------------------
  always_comb begin
    alu.acc = acc;
    alu.bit_sel = bit_q;
    alu.operand = (state == ST_IDLE) ? instr_imm : dmem_rdata;
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_op_q = op_q;
    next_bit_q = bit_q;
    next_acc = acc;
    next_zero_flag = zero_flag;
    next_table_high = table_high_byte_reg;
    next_dmem_addr = dmem_addr;
    next_dmem_wdata = dmem_wdata;
    next_pmem_addr = pmem_addr;
    next_dmem_rd = 1'b0;
    next_dmem_we = 1'b0;
    next_pmem_rd = 1'b0;
    next_done = 1'b0;
    next_skip = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_op_q = instr_op;
          next_bit_q = instr_bit;
          next_dmem_addr = instr_addr;
          unique case (instr_op)
            OP_XOR_IMMEDIATE: begin
              next_acc = alu.xor_result;
              next_zero_flag = alu.xor_zero;
              next_done = 1'b1;
            end
            OP_TABLE_READ_CURRENT: begin
              next_pmem_addr = cur_page_addr;
              next_pmem_rd = 1'b1;
              next_state = ST_TABLE;
            end
            OP_TABLE_READ_LAST_PAGE: begin
              next_pmem_addr = last_page_addr;
              next_pmem_rd = 1'b1;
              next_state = ST_TABLE;
            end
            default: begin
              next_dmem_rd = 1'b1;
              next_state = ST_DATA;
            end
          endcase
        end
      end
      ST_DATA: begin
        next_done = 1'b1;
        next_state = ST_IDLE;
        unique case (op_q)
          OP_SKIP_IF_BYTE_ZERO: begin
            // Byte is rewritten unchanged, which the load and bit tests do not do
            next_dmem_we = 1'b1;
            next_dmem_wdata = dmem_rdata;
            next_skip = alu.byte_zero;
          end
          OP_SKIP_IF_ZERO_LOAD_ACC: begin
            next_acc = dmem_rdata;
            next_skip = alu.byte_zero;
          end
          OP_SKIP_IF_BIT_ZERO: begin
            next_skip = alu.bit_clear;
          end
          OP_XOR_INTO_ACC: begin
            next_acc = alu.xor_result;
            next_zero_flag = alu.xor_zero;
          end
          OP_XOR_INTO_MEMORY: begin
            next_dmem_we = 1'b1;
            next_dmem_wdata = alu.xor_result;
            next_zero_flag = alu.xor_zero;
          end
          default: begin
            next_done = 1'b1;
          end
        endcase
        // Taken skip holds off the next request for the dummy slot
        if (next_skip) begin
          next_state = ST_DUMMY;
        end
      end
      ST_TABLE: begin
        next_dmem_we = 1'b1;
        next_dmem_wdata = pmem_rdata[PWORD_LO_LSB +: DATA_W];
        next_table_high = pmem_rdata[PWORD_HI_LSB +: DATA_W];
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      ST_DUMMY: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      op_q <= OP_SKIP_IF_BYTE_ZERO;
      bit_q <= '0;
      acc <= ACC_RST;
      zero_flag <= ZERO_FLAG_RST;
      table_high_byte_reg <= TABLE_HIGH_RST;
      dmem_addr <= '0;
      dmem_wdata <= '0;
      pmem_addr <= '0;
      dmem_rd <= 1'b0;
      dmem_we <= 1'b0;
      pmem_rd <= 1'b0;
      done <= 1'b0;
      skip <= 1'b0;
    end else begin
      state <= next_state;
      op_q <= next_op_q;
      bit_q <= next_bit_q;
      acc <= next_acc;
      zero_flag <= next_zero_flag;
      table_high_byte_reg <= next_table_high;
      dmem_addr <= next_dmem_addr;
      dmem_wdata <= next_dmem_wdata;
      pmem_addr <= next_pmem_addr;
      dmem_rd <= next_dmem_rd;
      dmem_we <= next_dmem_we;
      pmem_rd <= next_pmem_rd;
      done <= next_done;
      skip <= next_skip;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dummy_slot_s;
    state == ST_DUMMY && !instr_ready ##1 state == ST_IDLE;
  endsequence

  sequence table_store_s;
    dmem_we && done && dmem_wdata == $past(pmem_rdata[7:0])
      && table_high_byte_reg == $past(pmem_rdata[15:8]);
  endsequence

  byte_zero_wb_a: assert property (
    state == ST_DATA && op_q == OP_SKIP_IF_BYTE_ZERO |=> dmem_we
      && dmem_wdata == $past(dmem_rdata) && skip == ($past(dmem_rdata) == 8'h00)
      && $stable(zero_flag))
    else $error("byte zero test wrong");

  skip_dummy_a: assert property (
    skip |-> dummy_slot_s)
    else $error("taken skip without one dummy cycle");

  zero_load_a: assert property (
    state == ST_DATA && op_q == OP_SKIP_IF_ZERO_LOAD_ACC |=> acc == $past(dmem_rdata)
      && skip == (acc == 8'h00) && $stable(zero_flag))
    else $error("zero test with load wrong");

  bit_test_a: assert property (
    state == ST_DATA && op_q == OP_SKIP_IF_BIT_ZERO |=> skip == !$past(dmem_rdata[bit_q])
      && !dmem_we && $stable(acc) && $stable(zero_flag))
    else $error("bit zero test wrong");

  table_current_a: assert property (
    accept && instr_op == OP_TABLE_READ_CURRENT |=> pmem_rd
      && pmem_addr == $past(cur_page_addr) ##1 table_store_s)
    else $error("current table read wrong");

  last_page_a: assert property (
    accept && instr_op == OP_TABLE_READ_LAST_PAGE |=> pmem_rd
      && pmem_addr == $past(last_page_addr) ##1 table_store_s ##0 $stable(zero_flag))
    else $error("last page table read wrong");

  xor_acc_a: assert property (
    state == ST_DATA && op_q == OP_XOR_INTO_ACC |=> acc == ($past(acc) ^ $past(dmem_rdata))
      && !dmem_we && done)
    else $error("xor into accumulator wrong");

  xor_mem_a: assert property (
    state == ST_DATA && op_q == OP_XOR_INTO_MEMORY |=> dmem_we
      && dmem_wdata == ($past(acc) ^ $past(dmem_rdata)) && $stable(acc))
    else $error("xor into memory wrong");

  xor_imm_a: assert property (
    accept && instr_op == OP_XOR_IMMEDIATE |=> acc == ($past(acc) ^ $past(instr_imm))
      && done && instr_ready)
    else $error("xor immediate wrong");

  zero_update_a: assert property (
    (state == ST_DATA && (op_q == OP_XOR_INTO_ACC || op_q == OP_XOR_INTO_MEMORY))
      || (accept && instr_op == OP_XOR_IMMEDIATE)
      |=> zero_flag == (($past(acc) ^ $past(alu.operand)) == 8'h00))
    else $error("zero flag wrong after xor");

endmodule : skip_table_xor_exec

//--- mem_model.sv
`timescale 1ns/1ps
module mem_model #(
  parameter int DADDR_W = 8,
  parameter int PMEM_AW = 12
) (
  // Clock
  input wire logic clk,
  // Data memory
  input wire logic [DADDR_W-1:0] dmem_addr,
  input wire logic dmem_rd,
  output logic [skip_exec_pkg::DATA_W-1:0] dmem_rdata,
  input wire logic dmem_we,
  input wire logic [skip_exec_pkg::DATA_W-1:0] dmem_wdata,
  // Program memory
  input wire logic [PMEM_AW-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [skip_exec_pkg::PWORD_W-1:0] pmem_rdata
);
  import skip_exec_pkg::*;
  logic [DATA_W-1:0] dmem [0:(1<<DADDR_W)-1];
  logic [PWORD_W-1:0] pmem [0:(1<<PMEM_AW)-1];
  logic [DATA_W-1:0] d_last = 8'h00;
  logic [PWORD_W-1:0] p_last = 16'h0000;
  int wr_count = 0;
  // Idle read lines show the inverse of the last word, so stale use shows
  assign dmem_rdata = dmem_rd ? dmem[dmem_addr] : ~d_last;
  assign pmem_rdata = pmem_rd ? pmem[pmem_addr] : ~p_last;
  always @(posedge clk) begin
    if (dmem_rd) begin
      d_last <= dmem[dmem_addr];
    end
    if (pmem_rd) begin
      p_last <= pmem[pmem_addr];
    end
    if (dmem_we) begin
      dmem[dmem_addr] <= dmem_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule : mem_model

//--- skip_table_xor_exec_bench.sv
`timescale 1ns/1ps
module skip_table_xor_exec_bench;
  import skip_exec_pkg::*;
  logic clk, rst, instr_valid, instr_ready, done, skip, dmem_rd, dmem_we, pmem_rd, zero_flag;
  op_t instr_op;
  logic [7:0] instr_addr, instr_imm, dmem_addr, dmem_rdata, dmem_wdata, acc, tbl, ptr_lo, ptr_hi;
  logic [2:0] instr_bit;
  logic [11:0] pmem_addr;
  logic [15:0] pmem_rdata;
  int miscompares = 0;
  int check_count = 0;
  int w;

  skip_table_xor_exec dut_u (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_op(instr_op), .instr_addr(instr_addr),
    .instr_bit(instr_bit), .instr_imm(instr_imm), .done(done), .skip(skip),
    .table_pointer_low(ptr_lo), .table_pointer_high(ptr_hi), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .acc(acc),
    .zero_flag(zero_flag), .table_high_byte_reg(tbl));
  mem_model mem_u (.clk(clk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic exec(input op_t op, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] imm, input int cyc, input logic exp_skip);
    int n;
    @(posedge clk);
    instr_op <= op;
    instr_addr <= a;
    instr_bit <= b;
    instr_imm <= imm;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    // Done may already stand just after the take edge
    #1;
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("latency", cyc[15:0], n[15:0]);
    chk("skip", {15'h0, exp_skip}, {15'h0, skip});
    chk("ready_at_done", {15'h0, !exp_skip}, {15'h0, instr_ready});
    if (exp_skip) begin
      @(posedge clk);
      #1;
      chk("ready_after_dummy", 16'h0001, {15'h0, instr_ready});
    end
  endtask : exec

  task automatic state(input logic [7:0] ea, input logic ez);
    chk("acc", {8'h00, ea}, {8'h00, acc});
    chk("zero_flag", {15'h0, ez}, {15'h0, zero_flag});
  endtask : state

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_xor();
    exec(OP_XOR_IMMEDIATE, 8'h00, 3'h0, 8'h00, 1, 1'b0);
    state(8'h00, 1'b1);
    exec(OP_XOR_IMMEDIATE, 8'h00, 3'h0, 8'hA5, 1, 1'b0);
    state(8'hA5, 1'b0);
    mem_u.dmem[20] = 8'hA5;
    exec(OP_XOR_INTO_ACC, 8'h14, 3'h0, 8'h00, 2, 1'b0);
    state(8'h00, 1'b1);
    mem_u.dmem[21] = 8'h3C;
    exec(OP_XOR_INTO_ACC, 8'h15, 3'h0, 8'h00, 2, 1'b0);
    state(8'h3C, 1'b0);
    mem_u.dmem[22] = 8'h3C;
    exec(OP_XOR_INTO_MEMORY, 8'h16, 3'h0, 8'h00, 2, 1'b0);
    state(8'h3C, 1'b1);
    // Memory takes the write on the edge after done
    @(posedge clk);
    #1;
    chk("xor_mem_result", 16'h0000, {8'h00, mem_u.dmem[22]});
    $display("test xor done");
  endtask : t_xor

  task automatic t_zero_tests();
    mem_u.dmem[10] = 8'h00;
    w = mem_u.wr_count;
    exec(OP_SKIP_IF_BYTE_ZERO, 8'h0A, 3'h0, 8'h00, 2, 1'b1);
    chk("byte_zero_writes", w[15:0] + 16'h0001, mem_u.wr_count[15:0]);
    mem_u.dmem[11] = 8'h80;
    exec(OP_SKIP_IF_BYTE_ZERO, 8'h0B, 3'h0, 8'h00, 2, 1'b0);
    @(posedge clk);
    #1;
    chk("byte_zero_mem", 16'h0080, {8'h00, mem_u.dmem[11]});
    state(8'h3C, 1'b1);
    mem_u.dmem[30] = 8'h00;
    exec(OP_SKIP_IF_ZERO_LOAD_ACC, 8'h1E, 3'h0, 8'h00, 2, 1'b1);
    state(8'h00, 1'b1);
    mem_u.dmem[31] = 8'h5A;
    exec(OP_SKIP_IF_ZERO_LOAD_ACC, 8'h1F, 3'h0, 8'h00, 2, 1'b0);
    state(8'h5A, 1'b1);
    mem_u.dmem[40] = 8'hF7;
    w = mem_u.wr_count;
    for (int i = 0; i < 8; i++) begin
      exec(OP_SKIP_IF_BIT_ZERO, 8'h28, i[2:0], 8'h00, 2, i == 3);
    end
    chk("bit_writes", w[15:0], mem_u.wr_count[15:0]);
    state(8'h5A, 1'b1);
    $display("test zero_tests done");
  endtask : t_zero_tests

  task automatic t_table();
    mem_u.pmem[12'h345] = 16'hBEEF;
    mem_u.pmem[12'hF45] = 16'h1234;
    exec(OP_TABLE_READ_CURRENT, 8'h32, 3'h0, 8'h00, 2, 1'b0);
    @(posedge clk);
    #1;
    chk("tab_low", 16'h00EF, {8'h00, mem_u.dmem[50]});
    chk("tab_high", 16'h00BE, {8'h00, tbl});
    exec(OP_TABLE_READ_LAST_PAGE, 8'h33, 3'h0, 8'h00, 2, 1'b0);
    @(posedge clk);
    #1;
    chk("last_low", 16'h0034, {8'h00, mem_u.dmem[51]});
    chk("last_high", 16'h0012, {8'h00, tbl});
    state(8'h5A, 1'b1);
    $display("test table done");
  endtask : t_table

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100_000;
    miscompares++;
    results();
  end

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_op = OP_XOR_IMMEDIATE;
    instr_addr = 8'h00;
    instr_bit = 3'h0;
    instr_imm = 8'h00;
    ptr_lo = 8'h45;
    ptr_hi = 8'h03;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    state(8'h00, 1'b0);
    chk("tbl_rst", 16'h0000, {8'h00, tbl});
    chk("ready_rst", 16'h0001, {15'h0, instr_ready});
    t_xor();
    t_zero_tests();
    t_table();
    results();
  end
endmodule : skip_table_xor_exec_bench
